// ### dv/rss_ctrl_props.sv
// Checker: concurrent properties for the reference select controller
`timescale 1ns/10ps
module rss_ctrl_props
    import rss_pkg::*;
(
    input wire logic      MCLK,         // Core clock
    input wire logic      RST,          // Sync reset, active high
    input wire logic      REF0_LOS,     // Input zero loss
    input wire rss_cfg_s  CFG,          // Control bits
    input wire rss_stat_s STATUS,       // Status bits
    input wire logic      LOCK_PIN,     // Lock pin
    input wire logic      HOLDOVER_PIN, // Holdover pin
    input wire logic      ALARM_PIN,    // Reference alarm pin
    input wire rss_byp_e  BYPASS_SEL    // Bypass source
);
    default clocking cb @(posedge MCLK); endclocking
    default disable iff (RST);
    AST_STATE_ENC: assert property (
        STATUS.state inside {RSS_ST_FREERUN, RSS_ST_LOCK, RSS_ST_HOLDOVER})
        else $error("illegal PLL state");
    AST_STATE_PINS: assert property (
        LOCK_PIN == (STATUS.state == RSS_ST_LOCK)
        && HOLDOVER_PIN == (STATUS.state == RSS_ST_HOLDOVER)
        && STATUS.lock == LOCK_PIN && STATUS.holdover == HOLDOVER_PIN)
        else $error("state pins disagree with state");
    AST_ALARM_PIN: assert property (
        |STATUS.los_alarm |-> ##[0:1] ALARM_PIN)
        else $error("alarm pin missing");
    AST_LOS_ALARM: assert property (
        $rose(REF0_LOS) |-> ##[1:4] STATUS.los_alarm[0])
        else $error("loss alarm late");
    // The alarm may only clear on a cycle whose synced loss line was low
    AST_VALID_ALARM: assert property (
        $fell(STATUS.los_alarm[0]) |-> !$past(REF0_LOS, 3)
        && STATUS.ref_valid[0])
        else $error("reference requalified while lost");
    AST_SYN_FREE: assert property (
        CFG.syn_mode && $past(CFG.syn_mode) |-> !STATUS.lock)
        else $error("locked in synthesizer mode");
    AST_LEAVE_FAILED: assert property (
        STATUS.lock && !STATUS.ref_valid[STATUS.active_ref]
        |=> !STATUS.lock || STATUS.active_ref != $past(STATUS.active_ref))
        else $error("still locked on failed reference");
    AST_HOLD_ALARM: assert property (
        $rose(STATUS.holdover) |-> ##[0:1] STATUS.hold_alarm)
        else $error("holdover alarm not set");
    AST_MANUAL_REF: assert property (
        STATUS.lock && CFG.ref_sel inside {RSS_SEL_REF0, RSS_SEL_REF1}
        && $past(CFG.ref_sel, 4) == CFG.ref_sel
        |-> STATUS.active_ref == CFG.ref_sel[1])
        else $error("manual lock on wrong input");
    AST_BYPASS: assert property (
        1'b1 |=> BYPASS_SEL == (($past(CFG.byp_src) == 2'h3)
        ? RSS_BYP_XTAL : $past(CFG.byp_src)))
        else $error("bypass source wrong");
    cover property (STATUS.state == RSS_ST_HOLDOVER);
    cover property ($changed(STATUS.active_ref) && STATUS.lock);
    cover property (CFG.ref_sel == RSS_SEL_PIN && STATUS.lock);
endmodule

bind rss_ctrl rss_ctrl_props chk_u (
    .MCLK         (MCLK),
    .RST          (RST),
    .REF0_LOS     (REF0_LOS),
    .CFG          (CFG),
    .STATUS       (STATUS),
    .LOCK_PIN     (LOCK_PIN),
    .HOLDOVER_PIN (HOLDOVER_PIN),
    .ALARM_PIN    (ALARM_PIN),
    .BYPASS_SEL   (BYPASS_SEL)
);

// ### dv/rss_ref_src.sv
// Reference source model: one input clock and its loss monitor
`timescale 1ns/10ps
module rss_ref_src (
    input  wire logic MCLK,     // Core clock
    input  wire logic run,      // Source present
    output logic      los,      // Loss indication, high while silent
    output logic      edge_tgl  // Toggles once per reference rising edge
);
    logic [1:0] div_reg;
    initial begin
        los = 1'b1;
        edge_tgl = 1'b0;
        div_reg = 2'h0;
    end
    // Edges every fourth cycle keep the toggle spacing above three cycles
    always @(negedge MCLK) begin
        los <= !run;
        if (run) begin
            div_reg <= div_reg + 2'h1;
            if (div_reg == 2'h3) edge_tgl <= !edge_tgl;
        end else begin
            div_reg <= 2'h0; // A silent source stands still
        end
    end
endmodule

// ### dv/tb.sv
// Self-checking bench for the reference select and state controller
`timescale 1ns/10ps
module tb;
    import rss_pkg::*;
    typedef struct packed {
        rss_cfg_s   cfg;
        logic [2:0] src;  // Source one, source zero, select pin
        rss_state_e st;
        logic       act;
    } rss_row_s;
    logic      MCLK, RST, run0, run1, CLOCK_SELECT, HOLD_ALARM_CLR;
    logic      REF0_LOS, REF1_LOS, REF0_EDGE, REF1_EDGE;
    logic      LOCK_PIN, HOLDOVER_PIN, ALARM_PIN;
    rss_cfg_s  CFG;
    rss_stat_s STATUS;
    rss_byp_e  BYPASS_SEL;
    rss_row_s  rows[$];
    int        n_fail, checks;

    rss_ref_src src0_u (.MCLK(MCLK), .run(run0), .los(REF0_LOS),
                        .edge_tgl(REF0_EDGE));
    rss_ref_src src1_u (.MCLK(MCLK), .run(run1), .los(REF1_LOS),
                        .edge_tgl(REF1_EDGE));
    rss_ctrl dut_u (.MCLK(MCLK), .RST(RST), .REF0_LOS(REF0_LOS),
        .REF1_LOS(REF1_LOS), .REF0_EDGE(REF0_EDGE), .REF1_EDGE(REF1_EDGE),
        .CLOCK_SELECT(CLOCK_SELECT), .CFG(CFG),
        .HOLD_ALARM_CLR(HOLD_ALARM_CLR), .STATUS(STATUS),
        .LOCK_PIN(LOCK_PIN), .HOLDOVER_PIN(HOLDOVER_PIN),
        .ALARM_PIN(ALARM_PIN), .BYPASS_SEL(BYPASS_SEL));

    task automatic chk(input string what, input logic [7:0] seen,
                       input logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("unexpected %s: expected %0h seen %0h", what, exp, seen);
        end
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge MCLK);
    endtask
    task automatic add(input rss_sel_e s, input logic rv, pr, sy,
                       input logic [2:0] src, input rss_state_e st,
                       input logic act);
        rss_row_s   r;
        logic [1:0] b;
        b = 2'(rows.size()); // Bypass source walks all four codes
        r.cfg = '{s, rv, pr, sy, rss_byp_e'(b)};
        r.src = src;
        r.st = st;
        r.act = act;
        rows.push_back(r);
    endtask
    // Reset values are checked while the reset is still held
    task automatic do_reset();
        RST <= 1'b1;
        cyc(10);
        chk("reset state", 8'(STATUS.state), 8'(RSS_ST_FREERUN));
        chk("reset pins", 8'({LOCK_PIN, HOLDOVER_PIN}), 8'h00);
        chk("reset bypass", 8'(BYPASS_SEL), 8'h00);
        chk("reset valid", 8'(STATUS.ref_valid), 8'h00);
        chk("reset alarms", 8'(STATUS.los_alarm), 8'h03);
        chk("reset hold alarm", 8'(STATUS.hold_alarm), 8'h00);
        RST <= 1'b0;
        $display("test reset done");
    endtask

    initial begin
        MCLK = 1'b0;
        forever #12.5 MCLK = ~MCLK;
    end
    initial begin
        repeat (3000) @(posedge MCLK);
        n_fail++;
        $display("watchdog expired");
        conclude();
    end
    initial begin
        RST = 1'b1;
        run0 = 1'b0;
        run1 = 1'b0;
        CLOCK_SELECT = 1'b0;
        HOLD_ALARM_CLR = 1'b0;
        CFG = '0;
        n_fail = 0;
        checks = 0;
        add(RSS_SEL_AUTO, 1, 0, 0, 3'b000, RSS_ST_FREERUN, 0);
        add(RSS_SEL_AUTO, 1, 0, 0, 3'b010, RSS_ST_LOCK, 0);
        add(RSS_SEL_AUTO, 1, 0, 0, 3'b110, RSS_ST_LOCK, 0);
        add(RSS_SEL_AUTO, 1, 0, 0, 3'b100, RSS_ST_LOCK, 1);
        add(RSS_SEL_AUTO, 1, 0, 0, 3'b110, RSS_ST_LOCK, 0);
        add(RSS_SEL_AUTO, 0, 0, 0, 3'b100, RSS_ST_LOCK, 1);
        add(RSS_SEL_AUTO, 0, 0, 0, 3'b110, RSS_ST_LOCK, 1);
        add(RSS_SEL_AUTO, 1, 1, 0, 3'b110, RSS_ST_LOCK, 1);
        add(RSS_SEL_AUTO, 1, 1, 0, 3'b010, RSS_ST_LOCK, 0);
        add(RSS_SEL_AUTO, 1, 1, 0, 3'b110, RSS_ST_LOCK, 1);
        add(RSS_SEL_AUTO, 1, 1, 0, 3'b000, RSS_ST_HOLDOVER, 0);
        add(RSS_SEL_REF0, 0, 0, 0, 3'b110, RSS_ST_LOCK, 0);
        add(RSS_SEL_REF0, 0, 0, 0, 3'b100, RSS_ST_HOLDOVER, 0);
        add(RSS_SEL_PIN, 0, 0, 0, 3'b101, RSS_ST_LOCK, 1);
        add(RSS_SEL_PIN, 0, 0, 0, 3'b110, RSS_ST_LOCK, 0);
        add(RSS_SEL_REF1, 0, 0, 0, 3'b110, RSS_ST_LOCK, 1);
        add(RSS_SEL_REF1, 0, 0, 1, 3'b110, RSS_ST_FREERUN, 0);
        do_reset();
        foreach (rows[i]) begin
            CFG <= rows[i].cfg;
            {run1, run0, CLOCK_SELECT} <= rows[i].src;
            cyc(60);
            chk("state", 8'(STATUS.state), 8'(rows[i].st));
            if (rows[i].st == RSS_ST_LOCK)
                chk("active", 8'(STATUS.active_ref), 8'(rows[i].act));
            chk("pins", 8'({LOCK_PIN, HOLDOVER_PIN}),
                8'({rows[i].st == RSS_ST_LOCK,
                    rows[i].st == RSS_ST_HOLDOVER}));
            chk("alarm", 8'(ALARM_PIN), 8'(~&rows[i].src[2:1]));
            chk("bypass", 8'(BYPASS_SEL),
                (rows[i].cfg.byp_src == 2'h3) ? 8'h00
                : 8'(rows[i].cfg.byp_src));
        end
        $display("test rows done");
        chk("hold alarm", 8'(STATUS.hold_alarm), 8'h01);
        HOLD_ALARM_CLR <= 1'b1;
        cyc(1);
        HOLD_ALARM_CLR <= 1'b0;
        cyc(2);
        chk("hold alarm clear", 8'(STATUS.hold_alarm), 8'h00);
        $display("test hold alarm done");
        // A loss in mid-count must throw away the edges already seen
        CFG <= '0;
        run0 <= 1'b0;
        run1 <= 1'b0;
        cyc(10);
        run0 <= 1'b1;
        cyc(20);
        run0 <= 1'b0;
        cyc(4);
        run0 <= 1'b1;
        cyc(30);
        chk("valid early", 8'(STATUS.ref_valid[0]), 8'h00);
        cyc(10);
        chk("valid late", 8'(STATUS.ref_valid[0]), 8'h01);
        $display("test revalidation done");
        cyc(10);
        do_reset();
        cyc(60);
        chk("relock", 8'(STATUS.state), 8'(RSS_ST_LOCK));
        $display("test second reset done");
        conclude();
    end
endmodule

// ### rtl/rss_ctrl.sv
// Top: PLL state machine and reference selection
`timescale 1ns/10ps
module rss_ctrl
    import rss_pkg::*;
(
    input  wire logic       MCLK,           // Core clock, 40 MHz
    input  wire logic       RST,            // Sync reset, active high
    input  wire logic       REF0_LOS,       // Input zero loss, async
    input  wire logic       REF1_LOS,       // Input one loss, async
    input  wire logic       REF0_EDGE,      // Input zero edge toggle, async
    input  wire logic       REF1_EDGE,      // Input one edge toggle, async
    input  wire logic       CLOCK_SELECT,   // Select pin level, async
    input  wire rss_cfg_s   CFG,            // Control bits
    input  wire logic       HOLD_ALARM_CLR, // Clear holdover alarm pulse
    output rss_stat_s       STATUS,         // Status bits
    output logic            LOCK_PIN,       // Lock indication pin
    output logic            HOLDOVER_PIN,   // Holdover indication pin
    output logic            ALARM_PIN,      // Any reference alarm pin
    output rss_byp_e        BYPASS_SEL      // Output-three bypass source
);
    //-----------------------------------------------------------------------
    // Input synchronisers
    //-----------------------------------------------------------------------
    logic [3:0] sync1_reg;
    logic [3:0] sync2_reg;
    logic [1:0] edge_d_reg;
    wire  [3:0] async_in = {CLOCK_SELECT, REF1_EDGE, REF0_EDGE, REF1_LOS};

    logic       los0_s1_reg;
    logic       los0_s2_reg;

    // Synchronisers run through reset: the toggle history then matches
    // the pins when reset lifts, so no false edge is counted after it
    always_ff @(posedge MCLK) begin
        sync1_reg   <= async_in;
        sync2_reg   <= sync1_reg;
        los0_s1_reg <= REF0_LOS;
        los0_s2_reg <= los0_s1_reg;
        edge_d_reg  <= sync2_reg[2:1];
    end

    wire       clock_select_input_sync = sync2_reg[3];
    wire [1:0] los_sync  = {sync2_reg[0], los0_s2_reg};
    // Edges arrive as toggles so slow core sampling never misses one
    wire [1:0] edge_pls  = sync2_reg[2:1] ^ edge_d_reg;

    //-----------------------------------------------------------------------
    // Reference validation
    //-----------------------------------------------------------------------
    logic [1:0] ref_valid;
    logic [1:0] los_alarm;

    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : gen_ref
            rss_ref_valid #(
                .EDGES     (VALID_EDGES)
            ) u_valid (
                .clk       (MCLK),
                .rst       (RST),
                .los_in    (los_sync[g]),
                .edge_in   (edge_pls[g]),
                .valid     (ref_valid[g]),
                .los_alarm (los_alarm[g])
            );
        end
    endgenerate

    //-----------------------------------------------------------------------
    // Reference choice
    //-----------------------------------------------------------------------
    rss_state_e state_reg;
    rss_state_e state_next;
    logic       active_reg;
    logic       active_next;
    logic       hold_alm_reg;
    logic       hold_alm_next;

    wire manual     = (CFG.ref_sel != RSS_SEL_AUTO);
    // Manual target: field direct, or the pin when in pin-select mode
    wire man_ref    = (CFG.ref_sel == RSS_SEL_PIN) ? clock_select_input_sync
                                                   : (CFG.ref_sel ==
                                                      RSS_SEL_REF1);
    wire hi_ref     = CFG.pri_ref1;
    wire lo_ref     = ~CFG.pri_ref1;
    wire hi_valid   = ref_valid[hi_ref];
    wire lo_valid   = ref_valid[lo_ref];
    wire any_valid  = hi_valid | lo_valid;
    wire act_valid  = ref_valid[active_reg];
    // Highest-priority valid input; the lower-priority input when neither is valid
    wire best_ref   = hi_valid ? hi_ref : lo_ref;
    wire man_valid  = ref_valid[man_ref];
    // Synthesizer mode pins the loop on the crystal
    wire syn        = CFG.syn_mode;

    always_comb begin
        state_next  = state_reg;
        active_next = active_reg;
        case (state_reg)
            RSS_ST_FREERUN: begin
                if (syn) begin
                    state_next = RSS_ST_FREERUN;
                end else if (manual) begin
                    active_next = man_ref;
                    if (man_valid) begin
                        state_next = RSS_ST_LOCK;
                    end
                end else if (any_valid) begin
                    active_next = best_ref;
                    state_next  = RSS_ST_LOCK;
                end
            end
            RSS_ST_LOCK: begin
                if (syn) begin
                    state_next = RSS_ST_FREERUN;
                end else if (manual) begin
                    // Only user command changes the reference
                    active_next = man_ref;
                    if (!man_valid) begin
                        state_next = RSS_ST_HOLDOVER;
                    end
                end else if (!act_valid) begin
                    if (any_valid) begin
                        active_next = best_ref;
                    end else begin
                        state_next = RSS_ST_HOLDOVER;
                    end
                end else if (CFG.revertive && hi_valid) begin
                    active_next = hi_ref;
                end else begin
                    active_next = active_reg;
                end
            end
            RSS_ST_HOLDOVER: begin
                if (syn) begin
                    state_next = RSS_ST_FREERUN;
                end else if (manual) begin
                    active_next = man_ref;
                    if (man_valid) begin
                        state_next = RSS_ST_LOCK;
                    end
                end else if (any_valid) begin
                    active_next = best_ref;
                    state_next  = RSS_ST_LOCK;
                end
            end
            default: begin
                state_next = RSS_ST_FREERUN;
            end
        endcase
    end

    // Set wins over a clear arriving in the same cycle
    wire entering_hold = (state_next == RSS_ST_HOLDOVER) &&
                         (state_reg != RSS_ST_HOLDOVER);
    assign hold_alm_next = entering_hold ? 1'b1
                         : (HOLD_ALARM_CLR ? 1'b0 : hold_alm_reg);

    always_ff @(posedge MCLK) begin
        if (RST) begin
            state_reg    <= RSS_ST_FREERUN;
            active_reg   <= 1'b0;
            hold_alm_reg <= 1'b0;
        end else begin
            state_reg    <= state_next;
            active_reg   <= active_next;
            hold_alm_reg <= hold_alm_next;
        end
    end

    //-----------------------------------------------------------------------
    // Outputs
    //-----------------------------------------------------------------------
    logic     lock_pin_reg;
    logic     hold_pin_reg;
    logic     alarm_pin_reg;
    rss_byp_e byp_reg;

    // Bypass is only legal for sources at or below 250 MHz; user's duty
    wire rss_byp_e byp_next = (CFG.byp_src == RSS_BYP_REF0) ? RSS_BYP_REF0
                            : (CFG.byp_src == RSS_BYP_REF1) ? RSS_BYP_REF1
                            : RSS_BYP_XTAL;

    always_ff @(posedge MCLK) begin
        if (RST) begin
            lock_pin_reg  <= 1'b0;
            hold_pin_reg  <= 1'b0;
            alarm_pin_reg <= 1'b0;
            byp_reg       <= RSS_BYP_XTAL;
        end else begin
            lock_pin_reg  <= (state_next == RSS_ST_LOCK);
            hold_pin_reg  <= (state_next == RSS_ST_HOLDOVER);
            alarm_pin_reg <= |los_alarm;
            byp_reg       <= byp_next;
        end
    end

    assign LOCK_PIN          = lock_pin_reg;
    assign HOLDOVER_PIN      = hold_pin_reg;
    assign ALARM_PIN         = alarm_pin_reg;
    assign BYPASS_SEL        = byp_reg;
    assign STATUS = '{state:      state_reg,
                      active_ref: active_reg,
                      lock:       lock_pin_reg,
                      holdover:   hold_pin_reg,
                      ref_valid:  ref_valid,
                      los_alarm:  los_alarm,
                      hold_alarm: hold_alm_reg};
endmodule

// ### rtl/rss_pkg.sv
// Package: constants and types for the reference select and state control
//---------------------------------------------------------------------------
// Function
// - After reset the PLL state is Free-run, tracking only the crystal.
// - Exactly one of Lock, Holdover, Free-run; lock and holdover shown.
// - With no valid reference ever present, stay in Free-run.
// - A validated eligible reference moves the PLL into Lock on it.
// - Auto mode: active fails, no other valid, go to Holdover.
// - Auto mode: active fails, other valid, switch hitlessly to it.
// - Manual mode: reference changes only by field or select pin.
// - Manual mode: one eligible input; its failure gives Holdover.
// - Select field offers direct input choice and a pin-select mode.
// - Pin-select: select pin low picks input zero, high picks one.
// - Auto mode: at start or failure pick highest-priority valid input.
// - Revertive: switch to higher-priority input once it becomes valid.
// - Non-revertive: keep current input while it stays valid.
// - One priority bit says which input is higher priority.
// - Bypass mux feeds crystal or either input to output-three divider.
// - Every input is monitored; an alarm is raised on failure.
// - Reset returns all registers and state machines to defaults; the input synchronisers are not reset.
// - Failed input valid again after eight edges; errors restart count.
// - Entering Holdover sets a separate sticky holdover alarm.
//---------------------------------------------------------------------------
package rss_pkg;

    localparam int unsigned VALID_EDGES = 8;
    localparam int unsigned VCNT_W      = 4;

    // Reference select field encoding
    typedef enum logic [1:0] {
        RSS_SEL_AUTO = 2'b00,
        RSS_SEL_REF0 = 2'b01,
        RSS_SEL_REF1 = 2'b10,
        RSS_SEL_PIN  = 2'b11
    } rss_sel_e;

    typedef enum logic [1:0] {
        RSS_ST_FREERUN  = 2'b00,
        RSS_ST_LOCK     = 2'b01,
        RSS_ST_HOLDOVER = 2'b10
    } rss_state_e;

    // Bypass mux source encoding
    typedef enum logic [1:0] {
        RSS_BYP_XTAL = 2'b00,
        RSS_BYP_REF0 = 2'b01,
        RSS_BYP_REF1 = 2'b10
    } rss_byp_e;

    typedef struct packed {
        rss_sel_e   ref_sel;
        logic       revertive;
        logic       pri_ref1;
        logic       syn_mode;
        rss_byp_e   byp_src;
    } rss_cfg_s;

    typedef struct packed {
        rss_state_e state;
        logic       active_ref;
        logic       lock;
        logic       holdover;
        logic [1:0] ref_valid;
        logic [1:0] los_alarm;
        logic       hold_alarm;
    } rss_stat_s;

endpackage

// ### rtl/rss_ref_valid.sv
// Per-reference validation: loss flag and eight-edge requalification
`timescale 1ns/10ps
module rss_ref_valid
    import rss_pkg::*;
#(
    parameter int unsigned EDGES = VALID_EDGES
) (
    input  wire logic clk,       // Core clock
    input  wire logic rst,       // Synchronous reset, active high
    input  wire logic los_in,    // Loss indication from monitor, synced
    input  wire logic edge_in,   // One-cycle pulse per reference rising edge
    output logic      valid,     // Reference qualified
    output logic      los_alarm  // Loss alarm, held until revalidated
);
    logic [VCNT_W-1:0] cnt_reg;
    logic [VCNT_W-1:0] cnt_next;
    logic              alm_reg;
    logic              alm_next;
    wire               cnt_done = (cnt_reg == VCNT_W'(EDGES - 1));

    // A fresh loss restarts the count, even mid-validation
    always_comb begin
        cnt_next = cnt_reg;
        alm_next = alm_reg;
        if (los_in) begin
            alm_next = 1'b1;
            cnt_next = '0;
        end else if (alm_reg && edge_in) begin
            if (cnt_done) begin
                alm_next = 1'b0;
                cnt_next = '0;
            end else begin
                cnt_next = cnt_reg + VCNT_W'(1);
            end
        end
    end

    // Starts failed: nothing counts as valid until it has shown edges
    always_ff @(posedge clk) begin
        if (rst) begin
            cnt_reg <= '0;
            alm_reg <= 1'b1;
        end else begin
            cnt_reg <= cnt_next;
            alm_reg <= alm_next;
        end
    end

    assign valid     = ~alm_reg;
    assign los_alarm = alm_reg;
endmodule
